// ==== design/jsdtx_link_tx.sv ====
// Link layer of the serial data transmitter: lane spreading, handshake,
// multiframe timing and alignment sequence ahead of the line encoders.
// Assumes synchronous inputs, static configuration while running, and
// external 8b/10b or 64b/66b encoders and serializers on ref_clk.
`timescale 1ns/1ps

module jsdtx_link_tx #(parameter int LANES = jsdtx_pkg::LANE_MAX)
(
   // Device clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   // Configuration
   input  wire logic                 coding_64b66b,
   input  wire logic [3:0]           lane_count,
   input  wire logic [7:0]           frame_octets,
   input  wire logic [8:0]           mf_frames,
   input  wire logic [7:0]           emb_blocks,
   input  wire logic                 fec_enable,
   input  wire logic                 nco_sync_enable,
   // Link control pins
   input  wire logic                 single_ended_sync_pin_n,
   input  wire logic                 sysref,
   // Sample stream
   input  wire logic                 sample_valid,
   output      logic                 sample_ready,
   input  wire logic [LANES*8-1:0]   sample_data,
   // Lane octets toward the encoders
   output      logic [LANES*8-1:0]   lane_octet,
   output      logic [LANES-1:0]     lane_control,
   output      logic [LANES-1:0]     lane_enable,
   output      logic                 lane_sample,
   output      logic                 block_start,
   output      logic [1:0]           block_header,
   output      logic                 fec_active,
   // Status
   output      logic [1:0]           link_state,
   output      logic                 sync_error,
   output      logic                 nco_sync
);

   jsdtx_stream_if #(.WIDTH(LANES*8)) stream ();

   jsdtx_pkg::jsdtx_state_type state;
   jsdtx_pkg::jsdtx_state_type next_state;
   logic [15:0] mf_cnt;
   logic [15:0] mf_period;
   logic        mf_edge;
   logic        mf_last;
   logic        sysref_prev;
   logic        sync_prev;
   logic        sync_rise;
   logic        sync_fall;
   logic [7:0]  low_cnt;
   logic        long_low;
   logic        armed;
   logic [1:0]  ilas_mf;
   logic        mode_prev;
   logic [LANES-1:0] mask;

   // Octets per multiframe (8b/10b) or per extended multiblock (64b/66b)
   function automatic logic [15:0] calc_period(input logic       is64,
                                               input logic [7:0] f,
                                               input logic [8:0] k,
                                               input logic [7:0] e);
      logic [16:0] p;
      p = 17'h0;
      if (is64)
      begin
         p = 17'(e) << jsdtx_pkg::BLOCK_OCTETS_SHIFT;
      end
      else
      begin
         p = {9'h0, f} * {8'h0, k};
      end
      if (p[15:0] == 16'h0)
      begin
         p = 17'h1;
      end
      return p[15:0];
   endfunction : calc_period

   // Ones for each active lane
   function automatic logic [LANES-1:0] lane_mask(input logic [3:0] cnt);
      logic [LANES-1:0] m;
      m = '0;
      for (int i = 0; i < LANES; i++)
      begin
         if ((i < int'(cnt)) || (cnt == 4'h0))
         begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction : lane_mask

   // Alignment sequence character: control flag and octet
   function automatic logic [8:0] ilas_char(input logic [1:0]  mf,
                                            input logic [15:0] pos,
                                            input logic [15:0] per,
                                            input logic [7:0]  lane,
                                            input logic [3:0]  lcnt,
                                            input logic [7:0]  f,
                                            input logic [8:0]  k);
      logic [8:0] c;
      c = {1'b0, pos[7:0]};
      if (pos == 16'h0)
      begin
         c = {1'b1, jsdtx_pkg::K28_0_START};
      end
      else if (pos == per - 16'h1)
      begin
         c = {1'b1, jsdtx_pkg::K28_3_ALIGN};
      end
      else if (mf == 2'h1)
      begin
         if (pos == 16'h1)
            c = {1'b1, jsdtx_pkg::K28_4_CONFIG};
         else if (pos == 16'h2)
            c = {1'b0, lane};
         else if (pos == 16'h3)
            c = ((lcnt == 4'h0) || (int'(lcnt) > LANES)) ?
                9'(LANES - 1) : {1'b0, 4'h0, lcnt - 4'h1};
         else if (pos == 16'h4)
            c = {1'b0, f - 8'h1};
         else if (pos == 16'h5)
            c = {1'b0, k[7:0] - 8'h1};
      end
      return c;
   endfunction : ilas_char

   // Word buffer so that a stalled lane path loses nothing
   jsdtx_pair_buffer #(.WIDTH(LANES*8)) u_buffer
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .in_valid (sample_valid),
      .in_ready (sample_ready),
      .in_data  (sample_data),
      .out      (stream.source)
   );

   // Words drain only while the link carries data
   assign stream.ready = (state == jsdtx_pkg::ST_DATA);

   // Local multiframe or extended multiblock timing, one octet per cycle
   assign mf_period = calc_period(coding_64b66b, frame_octets,
                                  mf_frames, emb_blocks);
   assign mf_edge   = (mf_cnt == jsdtx_pkg::MF_CNT_RESET);
   assign mf_last   = (mf_cnt >= mf_period - 16'h1);
   assign mask      = lane_mask(lane_count);

   // Handshake edges, sampled on the device clock
   assign sync_rise = single_ended_sync_pin_n && !sync_prev;
   assign sync_fall = !single_ended_sync_pin_n && sync_prev;
   assign long_low  = (low_cnt >= jsdtx_pkg::SYNC_REINIT_OCTETS);

   // Edge detectors for reference and handshake
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sysref_prev <= 1'b0;
         sync_prev   <= 1'b1;
         mode_prev   <= 1'b0;
      end
      else
      begin
         sysref_prev <= sysref;
         sync_prev   <= single_ended_sync_pin_n;
         mode_prev   <= coding_64b66b;
      end
   end

   // Multiframe counter; a reference rise restarts it in either coding
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         mf_cnt <= jsdtx_pkg::MF_CNT_RESET;
      end
      else if (sysref && !sysref_prev)
      begin
         mf_cnt <= jsdtx_pkg::MF_CNT_RESET;
      end
      else if (mf_last)
      begin
         mf_cnt <= jsdtx_pkg::MF_CNT_RESET;
      end
      else
      begin
         mf_cnt <= mf_cnt + 16'h1;
      end
   end

   // Length of current low on the handshake, saturating
   always_ff @(posedge ref_clk)
   begin
      if (rst || single_ended_sync_pin_n)
      begin
         low_cnt <= 8'h0;
      end
      else if (!long_low)
      begin
         low_cnt <= low_cnt + 8'h1;
      end
   end

   // Release seen, waiting for the next multiframe edge
   always_ff @(posedge ref_clk)
   begin
      if (rst || state != jsdtx_pkg::ST_CGS)
      begin
         armed <= 1'b0;
      end
      else if (sync_rise)
      begin
         armed <= 1'b1;
      end
   end

   // Multiframe index inside the alignment sequence
   always_ff @(posedge ref_clk)
   begin
      if (rst || state != jsdtx_pkg::ST_ILAS)
      begin
         ilas_mf <= 2'h0;
      end
      else if (mf_last)
      begin
         ilas_mf <= ilas_mf + 2'h1;
      end
   end

   // Link state sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         jsdtx_pkg::ST_IDLE:
         begin
            if (coding_64b66b)
            begin
               if (mf_edge)
                  next_state = jsdtx_pkg::ST_DATA;
            end
            else if (!single_ended_sync_pin_n)
            begin
               next_state = jsdtx_pkg::ST_CGS;
            end
         end
         jsdtx_pkg::ST_CGS:
         begin
            // Enter on the last octet so the sequence opens at count zero
            if (armed && mf_last && single_ended_sync_pin_n)
               next_state = jsdtx_pkg::ST_ILAS;
         end
         jsdtx_pkg::ST_ILAS:
         begin
            if (long_low)
               next_state = jsdtx_pkg::ST_CGS;
            else if (mf_last && ilas_mf == jsdtx_pkg::ILAS_LAST_MF)
               next_state = jsdtx_pkg::ST_DATA;
         end
         jsdtx_pkg::ST_DATA:
         begin
            if (!coding_64b66b && long_low)
               next_state = jsdtx_pkg::ST_CGS;
         end
         default:
         begin
            next_state = jsdtx_pkg::ST_IDLE;
         end
      endcase
   end

   // State register; a coding change restarts the link
   always_ff @(posedge ref_clk)
   begin
      if (rst || (coding_64b66b != mode_prev))
      begin
         state <= jsdtx_pkg::ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Short handshake lows in the 8b/10b data state are error reports, not requests
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sync_error <= 1'b0;
      end
      else
      begin
         sync_error <= !coding_64b66b && sync_rise && !long_low
                       && (state == jsdtx_pkg::ST_DATA);
      end
   end

   // Handshake low edge feeds oscillator sync only in 64b/66b mode
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         nco_sync <= 1'b0;
      end
      else
      begin
         nco_sync <= coding_64b66b && nco_sync_enable && sync_fall;
      end
   end

   // Per-lane octet generation; all lanes share one counter and state
   for (genvar g = 0; g < LANES; g++)
   begin : g_lane
      always_ff @(posedge ref_clk)
      begin
         if (rst || !mask[g])
         begin
            lane_octet[g*8 +: 8] <= 8'h0;
            lane_control[g]      <= 1'b0;
         end
         else
         begin
            case (state)
               jsdtx_pkg::ST_CGS:
               begin
                  lane_octet[g*8 +: 8] <= jsdtx_pkg::K28_5_COMMA;
                  lane_control[g]      <= 1'b1;
               end
               jsdtx_pkg::ST_ILAS:
               begin
                  {lane_control[g], lane_octet[g*8 +: 8]} <=
                     ilas_char(ilas_mf, mf_cnt, mf_period, 8'(g),
                               lane_count, frame_octets, mf_frames);
               end
               jsdtx_pkg::ST_DATA:
               begin
                  lane_octet[g*8 +: 8] <= stream.valid ?
                                          stream.data[g*8 +: 8] : 8'h0;
                  lane_control[g]      <= 1'b0;
               end
               default:
               begin
                  lane_octet[g*8 +: 8] <= 8'h0;
                  lane_control[g]      <= 1'b0;
               end
            endcase
         end
      end
   end

   // Per-lane enables and framing flags shared by every lane
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         lane_enable  <= '0;
         lane_sample  <= 1'b0;
         block_start  <= 1'b0;
         block_header <= 2'h0;
         fec_active   <= 1'b0;
      end
      else
      begin
         lane_enable  <= mask;
         lane_sample  <= (state == jsdtx_pkg::ST_DATA) && stream.valid;
         block_start  <= coding_64b66b && (mf_cnt[2:0] == 3'h0);
         // Plain data header; no CRC or command bits are carried
         block_header <= coding_64b66b ? jsdtx_pkg::HDR_DATA : 2'h0;
         fec_active   <= coding_64b66b && fec_enable;
      end
   end

   // Link state shown outside
   assign link_state = state;

endmodule : jsdtx_link_tx

// ==== design/jsdtx_pkg.sv ====
// Shared constants and types of the serial link transmitter.
// Assumes one octet per lane per ref_clk cycle ahead of the line encoders.
package jsdtx_pkg;

   // Lane geometry
   localparam int LANE_MAX      = 8;
   localparam int OCTET_W       = 8;

   // Control characters sent ahead of the 8b/10b encoder
   localparam logic [7:0] K28_5_COMMA  = 8'hbc;
   localparam logic [7:0] K28_0_START  = 8'h1c;
   localparam logic [7:0] K28_3_ALIGN  = 8'h7c;
   localparam logic [7:0] K28_4_CONFIG = 8'h9c;

   // Index of the last multiframe of the alignment sequence (four in all)
   localparam logic [1:0] ILAS_LAST_MF = 2'h3;

   // 64b/66b block geometry
   localparam logic [7:0] BLOCK_OCTETS_SHIFT = 8'h08;
   localparam logic [1:0] HDR_DATA           = 2'h1;

   // Octets of continuous low handshake that force resynchronisation
   localparam logic [7:0] SYNC_REINIT_OCTETS = 8'h10;

   // Value of the multiframe counter after a reference event
   localparam logic [15:0] MF_CNT_RESET = 16'h0000;

   // Line coding selection
   typedef enum logic
   {
      CODE_8B10B  = 1'b0,
      CODE_64B66B = 1'b1
   } jsdtx_code_type;

   // Link states, Gray coded along idle, sync, align, data
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_CGS  = 2'b01,
      ST_ILAS = 2'b11,
      ST_DATA = 2'b10
   } jsdtx_state_type;

endpackage : jsdtx_pkg

// ==== design/jsdtx_stream_if.sv ====
// Valid and ready stream carrier between the buffer and the lane logic.
// Assumes both ends share one clock; carries no clock of its own.
`timescale 1ns/1ps

interface jsdtx_stream_if #(parameter int WIDTH = 64);

   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   // Side that offers words
   modport source (output valid, output data, input ready);
   // Side that takes words
   modport sink   (input valid, input data, output ready);

endinterface : jsdtx_stream_if

// ==== design/jsdtx_pair_buffer.sv ====
// Two-entry buffer for sample words ahead of the lane mapper.
// Assumes the sink may stall at any time; nothing is dropped.
`timescale 1ns/1ps

module jsdtx_pair_buffer #(parameter int WIDTH = 64)
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Filling side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   jsdtx_stream_if.source        out
);

   logic [WIDTH-1:0] store [2];
   logic             wr_ptr;
   logic             rd_ptr;
   logic [1:0]       fill;
   logic             push;
   logic             pop;

   // Handshake terms
   assign in_ready  = (fill != 2'h2);
   assign out.valid = (fill != 2'h0);
   assign out.data  = store[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out.valid && out.ready;

   // Storage write
   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         store[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fill   <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop)
         begin
            rd_ptr <= ~rd_ptr;
         end
         if (push && !pop)
         begin
            fill <= fill + 2'h1;
         end
         else if (pop && !push)
         begin
            fill <= fill - 2'h1;
         end
      end
   end

endmodule : jsdtx_pair_buffer

// ==== verification/jsdtx_link_monitor.sv ====
// Port assertions on the link transmitter, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module jsdtx_link_monitor #(parameter int LANES = 8)
(
   // Clock and reset
   input wire logic               ref_clk,
   input wire logic               rst,
   // Inputs watched
   input wire logic               coding_64b66b,
   input wire logic [3:0]         lane_count,
   input wire logic               fec_enable,
   input wire logic               nco_sync_enable,
   input wire logic               single_ended_sync_pin_n,
   // Outputs watched
   input wire logic [LANES*8-1:0] lane_octet,
   input wire logic [LANES-1:0]   lane_control,
   input wire logic [LANES-1:0]   lane_enable,
   input wire logic [1:0]         block_header,
   input wire logic               fec_active,
   input wire logic [1:0]         link_state,
   input wire logic               sync_error,
   input wire logic               nco_sync
);
   logic [LANES-1:0] en_mask;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Lane mask expected from the lane count
   always_comb
   begin
      en_mask = '1;
      if (lane_count != 4'h0 && lane_count < 4'h8)
         en_mask = LANES'((9'h1 << lane_count) - 9'h1);
   end

   // Checks on outputs against their causes
   hdr_fixed_a: assert property (
      !$past(rst) |-> block_header == {1'b0, $past(coding_64b66b)})
      else $error("block header wrong");
   fec_follow_a: assert property (
      !$past(rst) |-> fec_active == ($past(coding_64b66b)
      && $past(fec_enable))) else $error("fec flag wrong");
   sync_request_a: assert property (
      link_state == jsdtx_pkg::ST_IDLE && !coding_64b66b
      && !single_ended_sync_pin_n |=> link_state == jsdtx_pkg::ST_CGS)
      else $error("low handshake ignored");
   comma_out_a: assert property (
      link_state == jsdtx_pkg::ST_CGS && $past(link_state) ==
      jsdtx_pkg::ST_CGS |-> lane_control[0] && lane_octet[7:0] == 8'hbc)
      else $error("comma missing");
   align_hold_a: assert property (
      link_state == jsdtx_pkg::ST_CGS && !single_ended_sync_pin_n
      |=> link_state != jsdtx_pkg::ST_ILAS)
      else $error("alignment started while low");
   wide_states_a: assert property (
      !$past(rst) && $past(coding_64b66b) |-> link_state inside
      {jsdtx_pkg::ST_IDLE, jsdtx_pkg::ST_DATA})
      else $error("handshake state in wide coding");
   nco_pulse_a: assert property (
      coding_64b66b && nco_sync_enable && $fell(single_ended_sync_pin_n)
      |=> nco_sync) else $error("nco pulse missing");
   lane_mask_a: assert property (
      link_state == jsdtx_pkg::ST_DATA && $stable(lane_count)
      |-> lane_enable == en_mask) else $error("lane mask wrong");
   error_pulse_a: assert property (
      sync_error |=> !sync_error) else $error("error pulse too long");

   // Main scenarios reached
   cover property (link_state == jsdtx_pkg::ST_ILAS);
   cover property (sync_error);
   cover property (nco_sync);
endmodule : jsdtx_link_monitor

bind jsdtx_link_tx jsdtx_link_monitor #(.LANES(LANES)) mon (.ref_clk,
   .rst, .coding_64b66b, .lane_count, .fec_enable, .nco_sync_enable,
   .single_ended_sync_pin_n, .lane_octet, .lane_control, .lane_enable,
   .block_header, .fec_active, .link_state, .sync_error, .nco_sync);

// ==== verification/jsdtx_rx_model.sv ====
// Receiver model at the far end: owns the handshake pin.
// Assumes lane 0 octets and the frame sizes of the transmitter.
`timescale 1ns/1ps

module jsdtx_rx_model
(
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // Link settings
   input wire logic       coding_64b66b,
   input wire logic [7:0] frame_octets,
   input wire logic [8:0] mf_frames,
   input wire logic       sysref,
   // Lane 0 from the transmitter
   input wire logic [7:0] lane_octet0,
   input wire logic       lane_control0,
   // Bench commands
   input wire logic       pull_low,
   input wire logic       slow,
   // Handshake
   output logic           sync_n
);
   logic [15:0] lmfc;
   logic        sysref_d;
   logic [2:0]  commas;
   logic        waited;
   logic        asked;
   logic        linked;
   wire  [15:0] period = 16'(frame_octets) * 16'(mf_frames);
   wire         comma = lane_control0 && lane_octet0 == 8'hbc;

   // Local multiframe counter, restarted by a reference rise
   always_ff @(posedge ref_clk)
   begin
      sysref_d <= sysref;
      if (rst || (sysref && !sysref_d) || lmfc + 16'h1 >= period)
         lmfc <= 16'h0;
      else
         lmfc <= lmfc + 16'h1;
   end

   // Request sync, count commas, release on a multiframe edge
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sync_n <= 1'b1;
         asked  <= 1'b0;
         linked <= 1'b0;
      end
      else if (pull_low)
      begin
         sync_n <= 1'b0;
         commas <= 3'h0;
         waited <= 1'b0;
         if (comma)
            linked <= 1'b0;
      end
      else if (coding_64b66b || linked)
         sync_n <= 1'b1;
      else if (!asked)
      begin
         sync_n <= 1'b0;
         asked  <= 1'b1;
         commas <= 3'h0;
         waited <= 1'b0;
      end
      else if (commas != 3'h4)
         commas <= comma ? commas + 3'h1 : 3'h0;
      else if (lmfc == 16'h0 && slow && !waited)
         waited <= 1'b1;
      else if (lmfc == 16'h0)
      begin
         sync_n <= 1'b1;
         linked <= 1'b1;
      end
   end
endmodule : jsdtx_rx_model

// ==== verification/jsdtx_link_tx_bench.sv ====
// Self-checking bench for the link transmitter and a receiver model.
// Assumes F=2, K=4, E=1: a multiframe lasts eight cycles.
`timescale 1ns/1ps

module jsdtx_link_tx_bench;
   typedef struct {logic [3:0] cnt; logic [7:0] mask;} jsdtx_row_type;
   logic          ref_clk = 1'b0;
   logic          rst = 1'b1;
   logic          coding_64b66b = 1'b0;
   logic          fec_enable = 1'b0;
   logic          nco_sync_enable = 1'b0;
   logic [3:0]    lane_count = 4'h8;
   logic          sysref = 1'b0;
   logic          sample_valid = 1'b0;
   logic [63:0]   sample_data = 64'h0;
   logic          pull = 1'b0;
   logic          slow = 1'b0;
   logic          sample_ready, lane_sample, block_start, fec_active;
   logic          sync_error, nco_sync, single_ended_sync_pin_n;
   logic [63:0]   lane_octet, m;
   logic [7:0]    lane_control, lane_enable;
   logic [1:0]    block_header, link_state;
   logic [8:0]    cap [40];
   logic [63:0]   got [$];
   int            fails = 0, compares = 0, cyc = 0, n, k;
   int            e1, e2, s1, s2, c_err, c_nco, c_blk;
   int            ipos [8] = '{0, 7, 9, 10, 11, 12, 13, 31};
   logic [8:0]    ival [8] = '{9'h11c, 9'h17c, 9'h19c, 9'h001, 9'h007,
                               9'h001, 9'h003, 9'h17c};
   jsdtx_row_type rows [6] = '{'{4'h1, 8'h01}, '{4'h2, 8'h03},
      '{4'h4, 8'h0f}, '{4'h7, 8'h7f}, '{4'h8, 8'hff}, '{4'h0, 8'hff}};

   // Device clock and run ceiling
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         close_out();
      end
   end

   // Transmitter under test and its far end
   jsdtx_link_tx dut (.ref_clk, .rst, .coding_64b66b, .lane_count,
      .frame_octets(8'h02), .mf_frames(9'h004), .emb_blocks(8'h01),
      .fec_enable, .nco_sync_enable, .single_ended_sync_pin_n, .sysref,
      .sample_valid, .sample_ready, .sample_data, .lane_octet,
      .lane_control, .lane_enable, .lane_sample, .block_start,
      .block_header, .fec_active, .link_state, .sync_error, .nco_sync);
   jsdtx_rx_model rx (.ref_clk, .rst, .coding_64b66b,
      .frame_octets(8'h02), .mf_frames(9'h004), .sysref,
      .lane_octet0(lane_octet[7:0]), .lane_control0(lane_control[0]),
      .pull_low(pull), .slow, .sync_n(single_ended_sync_pin_n));

   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic close_out();
      $display("compares %0d, fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   task automatic wait_st(input logic [1:0] s);
      for (n = 0; n < 600 && link_state !== s; n++)
         @(negedge ref_clk);
      check("link state", link_state, s);
   endtask : wait_st

   // Offer a word and hold it until taken; valid stays up
   task automatic send(input logic [63:0] w);
      sample_valid = 1'b1;
      sample_data = w;
      for (n = 0; n < 50 && sample_ready !== 1'b1; n++)
         @(negedge ref_clk);
      @(negedge ref_clk);
   endtask : send

   task automatic pulse_ref(output int s);
      sysref = 1'b1;
      s = cyc;
      @(negedge ref_clk);
      sysref = 1'b0;
   endtask : pulse_ref

   task automatic pulses(input int c);
      c_err = 0;
      c_nco = 0;
      c_blk = 0;
      repeat (c)
      begin
         @(negedge ref_clk);
         c_err += int'(sync_error === 1'b1);
         c_nco += int'(nco_sync === 1'b1);
         c_blk += int'(block_start === 1'b1);
      end
   endtask : pulses

   // Capture the alignment sequence on lane 1 and any data words
   task automatic run_ilas(output int entry);
      wait_st(jsdtx_pkg::ST_ILAS);
      entry = cyc;
      n = 0;
      foreach (cap[i])
      begin
         cap[i] = {lane_control[1], lane_octet[15:8]};
         n += int'(link_state === jsdtx_pkg::ST_ILAS);
         if (lane_sample === 1'b1)
            got.push_back(lane_octet);
         @(negedge ref_clk);
      end
      k = (cap[0] === 9'h11c) ? 0 : 1;
      check("align length", n, 64'h20);
      foreach (ipos[i])
         check("align octet", cap[k + ipos[i]], ival[i]);
      $display("alignment sequence done");
   endtask : run_ilas

   // Reset, first link, lane rows, then the awkward cases
   initial
   begin
      repeat (8) @(negedge ref_clk);
      check("ready in reset", sample_ready, 1'b1);
      check("state in reset", link_state, 2'h0);
      rst = 1'b0;
      pulse_ref(s1);
      wait_st(jsdtx_pkg::ST_CGS);
      @(negedge ref_clk);
      check("comma", {lane_control[0], lane_octet[7:0]}, 9'h1bc);
      send(64'h1122334455667788);
      send(64'h99aabbccddeeff00);
      sample_valid = 1'b0;
      check("buffer full", sample_ready, 1'b0);
      run_ilas(e1);
      check("first word", got[0], 64'h1122334455667788);
      check("second word", got[1], 64'h99aabbccddeeff00);
      check("narrow header", block_header, 2'h0);
      foreach (rows[i])
      begin
         lane_count = rows[i].cnt;
         for (int b = 0; b < 8; b++)
            m[8*b +: 8] = {8{rows[i].mask[b]}};
         send(64'h0f1e2d3c4b5a6978 + 64'(i));
         sample_valid = 1'b0;
         for (n = 0; n < 20 && lane_sample !== 1'b1; n++)
            @(negedge ref_clk);
         check("lane data", lane_octet & m, sample_data & m);
         check("lane mask", lane_enable, rows[i].mask);
         $display("lane row %0d done", i);
      end
      pull = 1'b1;
      repeat (3) @(negedge ref_clk);
      pull = 1'b0;
      pulses(8);
      check("error pulse", c_err, 1);
      check("state kept", link_state, jsdtx_pkg::ST_DATA);
      pulse_ref(s2);
      slow = 1'b1;
      pull = 1'b1;
      repeat (20) @(negedge ref_clk);
      pull = 1'b0;
      check("resync", link_state, jsdtx_pkg::ST_CGS);
      run_ilas(e2);
      check("phase", (e2 - s2 - e1 + s1) % 8, 0);
      rst = 1'b1;
      coding_64b66b = 1'b1;
      fec_enable = 1'b1;
      nco_sync_enable = 1'b1;
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      wait_st(jsdtx_pkg::ST_DATA);
      check("wide header", block_header, 2'h1);
      check("fec on", fec_active, 1'b1);
      pull = 1'b1;
      repeat (1) @(negedge ref_clk);
      pull = 1'b0;
      pulses(16);
      check("nco pulse", c_nco, 1);
      check("block starts", c_blk, 2);
      check("no restart", link_state, jsdtx_pkg::ST_DATA);
      fec_enable = 1'b0;
      pulses(2);
      check("fec off", fec_active, 1'b0);
      $display("wide coding done");
      close_out();
   end
endmodule : jsdtx_link_tx_bench
